/* File: common/dmst_defines.svh */
// Purpose: Parameter addresses, codes, reset values and field positions
// Assumes: Parameters are addressed as menu number plus index within menu
// Notes:   Included by the core, the assertions and the bench; definitions only
`ifndef DMST_DEFINES_SVH
`define DMST_DEFINES_SVH

// Parameter addresses (menu, index)
`define DMST_MENU_BASIC      8'h00
`define DMST_MENU_TRIPS      8'h0a
`define DMST_IDX_UNLOCK      8'h00
`define DMST_IDX_MODE        8'h30
`define DMST_IDX_SECURITY    8'h31
`define DMST_IDX_VERSION     8'h32
`define DMST_IDX_TRIP_ACT    8'h33
`define DMST_IDX_TRIP_ALIAS  8'h25

// Unlock codes for mode change
`define DMST_UNLOCK_EUR      16'h04e5
`define DMST_UNLOCK_USA      16'h04e6

// Operating mode codes
`define DMST_MODE_OPEN_LOOP  3'h1
`define DMST_MODE_CL_VECTOR  3'h2
`define DMST_MODE_SERVO      3'h3
`define DMST_MODE_REGEN      3'h4

// Keypad security levels
`define DMST_SEC_MENU_ZERO   2'h0
`define DMST_SEC_ALL_MENUS   2'h1
`define DMST_SEC_LOCK_RESET  2'h2

// Version limits in hundredths (1.00 .. 99.99)
`define DMST_VER_MIN         16'h0064
`define DMST_VER_MAX         16'h270f

// Reset values and trip-action bit positions
`define DMST_RST_SECURITY    2'h0
`define DMST_RST_TRIP_ACT    4'h0
`define DMST_RST_UNLOCK      16'h0000
`define DMST_TA_STOP_FIRST   0
`define DMST_TA_NO_XTR_TRIP  1
`define DMST_TA_NO_PHASE     2
`define DMST_TA_NO_BRK_OPEN  3

`endif

/* File: common/dmst_pkg.sv */
// Purpose: Types shared by the mode, security and trip-policy block
// Assumes: Constants live in dmst_defines.svh
// Notes:   Request and fault groups travel as packed structs
package dmst_pkg;

	// Parameter access request from keypad or serial host
	typedef struct packed {
		logic        wr;          // Write strobe, one cycle
		logic        rd;          // Read strobe, one cycle
		logic        from_keypad; // Source is keypad, else serial
		logic [7:0]  menu;        // Menu number
		logic [7:0]  index;       // Index within menu
		logic [15:0] wdata;       // Write value
	} dmst_req_s;

	// Fault indications from the drive protection logic
	typedef struct packed {
		logic motor_thermistor_fault;  // Low priority
		logic heatsink_thermal_fault;  // Low priority
		logic output_overload_fault;   // Low priority
		logic analog_in2_current_loss; // Low priority
		logic analog_in3_current_loss; // Low priority
		logic serial_link_loss;        // Low priority
		logic braking_power_transistor; // Braking transistor protection
		logic phase_loss;              // Supply phase loss
		logic brake_thermistor_open;   // Resistor thermistor open circuit
		logic brake_resistor_hot;      // Resistor overheating
	} dmst_fault_s;

	// Cause of the latched trip
	typedef enum logic [2:0] {
		DMST_CAUSE_NONE,
		DMST_CAUSE_LOW_PRIO,
		DMST_CAUSE_XTR,
		DMST_CAUSE_PHASE,
		DMST_CAUSE_BRK_TEMP
	} dmst_cause_e;

	// Protection sequence state
	typedef enum logic [1:0] {
		DMST_ST_RUN,
		DMST_ST_STOPPING,
		DMST_ST_TRIPPED
	} dmst_state_e;

endpackage : dmst_pkg

/* File: core/dmst_config.sv */
// Purpose: Mode selector, keypad security, version and trip-action policy
// Assumes: Requests and faults come from logic on ref_clk_in; the reset
//          button and the frame strap are pins and are synchronised here
// Notes:   A request is answered by a one-cycle ack on the next edge
//
// Overview of operation
// (RULE1) Mode codes: 1 open, 2 vector, 3 servo, 4 regen
// (RULE2) Mode change needs unlock code 1253 or 1254
// (RULE3) Reset with new mode loads and stores defaults
// (RULE4) Mode write without unlock is ignored
// (RULE5) Level 0 keypad reaches menu zero only
// (RULE6) Level 1 keypad reaches all menus
// (RULE7) Level 2 locks at reset, becomes level 0
// (RULE8) Keypad may always change security level
// (RULE9) Version is read-only, 1.00 to 99.99
// (RULE10) Four-bit trip-action word, range 0-15, default 0
// (RULE11) Bit 0 clear: low-priority fault trips immediately
// (RULE12) Bit 0 set: stop then trip; regen immediate
// (RULE13) Bit 1 set suppresses braking transistor trips
// (RULE14) Bit 2 disables phase loss, 200V size 0 only
// (RULE15) Bit 3 clear: open thermistor raises resistor trip
// (RULE16) Bit 3 set suppresses open-thermistor detection; here only with the 200V size 0 strap
`include "dmst_defines.svh"

module dmst_config #(
	parameter logic [15:0] FW_VERSION   = 16'h0064, // Version in hundredths, arbitrary
	parameter logic [2:0]  DEFAULT_MODE = 3'h1      // Mode after power-up
) (
	input  wire logic                ref_clk_in,         // Control clock, 100 MHz
	input  wire logic                rst_n_in,           // Async reset, active low
	input  wire dmst_pkg::dmst_req_s req_in,             // Parameter request
	input  wire dmst_pkg::dmst_fault_s fault_in,         // Fault indications
	input  wire logic                motor_stopped_in,   // Motor at standstill
	input  wire logic                drive_reset_in,     // Reset button pin, high
	input  wire logic                size0_200v_in,      // Frame strap pin, high
	output logic [15:0]              param_rdata_out,    // Read value
	output logic                     param_ack_out,      // Request answered
	output logic                     param_err_out,      // Request refused
	output logic [2:0]               active_mode_out,    // Applied mode
	output logic                     defaults_usa_out,   // Last defaults were USA
	output logic                     defaults_load_out,  // Load mode defaults pulse
	output logic                     nv_store_out,       // Store to memory pulse
	output logic                     keypad_all_out,     // Keypad may reach all menus
	output logic                     security_locked_out, // User security locked
	output logic                     stop_request_out,   // Bring motor to stop
	output logic                     drive_trip_out,     // Drive tripped
	output dmst_pkg::dmst_cause_e    trip_cause_out      // Cause of trip
);
	import dmst_pkg::*;

	// Elaboration checks on parameters
	if (FW_VERSION < `DMST_VER_MIN || FW_VERSION > `DMST_VER_MAX) begin : g_chk_ver
		$error("FW_VERSION outside 1.00 to 99.99");
	end
	if (DEFAULT_MODE < `DMST_MODE_OPEN_LOOP || DEFAULT_MODE > `DMST_MODE_REGEN) begin : g_chk_mode
		$error("DEFAULT_MODE not a valid mode code");
	end

	// Stored parameters
	logic [15:0] unlock_code;          // general_unlock_parameter
	logic [2:0]  operating_mode_select; // Requested mode
	logic [2:0]  active_mode;          // Mode applied at last reset
	logic [1:0]  keypad_security_level; // Security level
	logic        sec_locked;           // Lock caught at reset
	logic [3:0]  trip_action_bits;     // Trip policy word

	// Pin synchronisers; first stages read only by second stages
	logic        rst_pin_s1;           // Reset pin, stage 1
	logic        rst_pin_s2;           // Reset pin, stage 2
	logic        rst_pin_d;            // Delayed for edge detect
	logic        strap_s1;             // Frame strap, stage 1
	logic        strap_s2;             // Frame strap, stage 2

	// Protection state
	dmst_state_e state;                // Sequence state
	dmst_state_e next_state;           // Next sequence state
	dmst_cause_e cause;                // Latched cause
	dmst_cause_e next_cause;           // Next cause

	// Pin synchronisers, two flops each
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Pins read low until sampled
			rst_pin_s1 <= 1'b0;
			rst_pin_s2 <= 1'b0;
			rst_pin_d  <= 1'b0;
			strap_s1   <= 1'b0;
			strap_s2   <= 1'b0;
		end else begin
			rst_pin_s1 <= drive_reset_in;
			rst_pin_s2 <= rst_pin_s1;
			rst_pin_d  <= rst_pin_s2;
			strap_s1   <= size0_200v_in;
			strap_s2   <= strap_s1;
		end
	end

	// Drive reset event on rising edge of the synchronised button
	wire reset_evt = rst_pin_s2 & ~rst_pin_d;

	// Address decode
	wire in_basic   = (req_in.menu == `DMST_MENU_BASIC);
	// Unlock sits at index 0 of any menu
	wire sel_unlock = (req_in.index == `DMST_IDX_UNLOCK);
	wire sel_mode   = in_basic & (req_in.index == `DMST_IDX_MODE);
	wire sel_sec    = in_basic & (req_in.index == `DMST_IDX_SECURITY);
	wire sel_ver    = in_basic & (req_in.index == `DMST_IDX_VERSION);
	wire sel_ta     = (in_basic & (req_in.index == `DMST_IDX_TRIP_ACT)) |
	                  ((req_in.menu == `DMST_MENU_TRIPS) &
	                   (req_in.index == `DMST_IDX_TRIP_ALIAS));
	wire sel_any    = sel_unlock | sel_mode | sel_sec | sel_ver | sel_ta;

	// Keypad access gate; the level itself always stays reachable
	wire level_zero = (keypad_security_level == `DMST_SEC_MENU_ZERO);
	wire kp_menu_ok = ~level_zero | in_basic;               // [RULE5] [RULE6]
	// A lock bars the keypad elsewhere
	wire kp_ok      = ~req_in.from_keypad | sel_sec |        // [RULE8]
	                  (kp_menu_ok & ~sec_locked);

	// Unlock check for mode change
	wire unlock_ok  = (unlock_code == `DMST_UNLOCK_EUR) |
	                  (unlock_code == `DMST_UNLOCK_USA);     // [RULE2]
	wire mode_valid = (req_in.wdata >= {13'h0000, `DMST_MODE_OPEN_LOOP}) &
	                  (req_in.wdata <= {13'h0000, `DMST_MODE_REGEN}); // [RULE1]

	// Value checks per parameter
	wire sec_valid  = (req_in.wdata <= {14'h0000, `DMST_SEC_LOCK_RESET});
	wire ta_valid   = (req_in.wdata[15:4] == 12'h000);       // [RULE10]

	// Write acceptance per target
	wire wr_ok      = req_in.wr & kp_ok;
	wire wr_unlock  = wr_ok & sel_unlock;
	wire wr_mode    = wr_ok & sel_mode &
	                  unlock_ok & mode_valid;                // [RULE4]
	wire wr_sec     = wr_ok & sel_sec & sec_valid;
	wire wr_ta      = wr_ok & sel_ta & ta_valid;

	// A write that stores nothing is refused; version never stores
	wire wr_refused = req_in.wr &
	                  ~(wr_unlock | wr_mode | wr_sec | wr_ta); // [RULE9]
	wire rd_refused = req_in.rd &
	                  (~sel_any | ~kp_ok);

	// Read multiplexer
	wire [15:0] rd_value =
		// Narrow values sit in the low bits
		sel_unlock ? unlock_code :
		sel_mode   ? {13'h0000, operating_mode_select} :
		sel_sec    ? {14'h0000, keypad_security_level} :
		sel_ver    ? FW_VERSION :                        // [RULE9]
		sel_ta     ? {12'h000, trip_action_bits} :
		             16'h0000;

	// Mode applies only at reset and only if it differs
	wire mode_change = reset_evt &
	                   (operating_mode_select != active_mode); // [RULE3]

	// Unlock code; cleared at drive reset so it returns to zero
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			unlock_code <= `DMST_RST_UNLOCK;
		end else if (wr_unlock) begin
			unlock_code <= req_in.wdata;
		end else if (reset_evt) begin
			// Each mode change needs a fresh code
			unlock_code <= `DMST_RST_UNLOCK;
		end
	end

	// Mode selector, guarded by the unlock code
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			operating_mode_select <= DEFAULT_MODE;
		end else if (wr_mode) begin                       // [RULE2] [RULE4]
			// Refused writes never get here
			operating_mode_select <= req_in.wdata[2:0];
		end
	end

	// Applied mode and defaults load with store
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_mode       <= DEFAULT_MODE;
			defaults_usa_out  <= 1'b0;
			defaults_load_out <= 1'b0;
			nv_store_out      <= 1'b0;
		end else begin
			defaults_load_out <= mode_change;             // [RULE3]
			nv_store_out      <= mode_change;             // [RULE3]
			if (mode_change) begin
				active_mode      <= operating_mode_select;
				// Code in force at reset picks the region
				defaults_usa_out <= (unlock_code == `DMST_UNLOCK_USA);
			end
		end
	end

	// Security level and lock; lock is caught on the drive reset
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			keypad_security_level <= `DMST_RST_SECURITY;
			sec_locked            <= 1'b0;
		end else if (reset_evt &&
		             keypad_security_level == `DMST_SEC_LOCK_RESET) begin
			// Lock wins over a write in the same cycle
			keypad_security_level <= `DMST_SEC_MENU_ZERO;  // [RULE7]
			sec_locked            <= 1'b1;                 // [RULE7]
		end else if (wr_sec) begin                        // [RULE8]
			keypad_security_level <= req_in.wdata[1:0];
			// Granting all menus is the way out of the lock
			if (req_in.wdata[1:0] == `DMST_SEC_ALL_MENUS) begin
				sec_locked <= 1'b0;
			end
		end
	end

	// Trip-action word, reached at both addresses
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			trip_action_bits <= `DMST_RST_TRIP_ACT;        // [RULE10]
		end else if (wr_ta) begin
			// Alias shares this storage
			trip_action_bits <= req_in.wdata[3:0];         // [RULE10]
		end
	end

	// Request answer, one cycle after the strobe
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			param_rdata_out <= 16'h0000;
			param_ack_out   <= 1'b0;
			param_err_out   <= 1'b0;
		end else begin
			// Every strobe is acked, refused or not
			param_ack_out   <= req_in.wr | req_in.rd;
			param_err_out   <= wr_refused | rd_refused;
			// Refused reads return zero so nothing leaks past security
			param_rdata_out <= (req_in.rd & ~rd_refused) ?
			                   rd_value : 16'h0000;
		end
	end

	// Fault qualification by the trip-action word
	wire low_prio  = fault_in.motor_thermistor_fault |
	                 fault_in.heatsink_thermal_fault |
	                 fault_in.output_overload_fault |
	                 fault_in.analog_in2_current_loss |
	                 fault_in.analog_in3_current_loss |
	                 fault_in.serial_link_loss;          // [RULE11]
	wire xtr_trip  = fault_in.braking_power_transistor &
	                 ~trip_action_bits[`DMST_TA_NO_XTR_TRIP]; // [RULE13]
	// Strap: the 200V smallest frame
	wire phase_trip = fault_in.phase_loss &
	                  ~(trip_action_bits[`DMST_TA_NO_PHASE] & strap_s2); // [RULE14]
	// Open thermistor also covers an unfitted resistor
	wire brk_open  = fault_in.brake_thermistor_open &
	                 ~(trip_action_bits[`DMST_TA_NO_BRK_OPEN] & strap_s2); // [RULE15] [RULE16]
	wire brk_trip  = brk_open | fault_in.brake_resistor_hot;
	// Resistor hot trips on every frame
	wire hi_trip   = xtr_trip | phase_trip | brk_trip;

	// Stop first only if asked and not in regen
	wire stop_first = trip_action_bits[`DMST_TA_STOP_FIRST] &
	                  (active_mode != `DMST_MODE_REGEN);  // [RULE12]

	// Cause of a high-priority trip, fixed priority order
	wire dmst_cause_e hi_cause =
		xtr_trip   ? DMST_CAUSE_XTR :
		phase_trip ? DMST_CAUSE_PHASE :
		             DMST_CAUSE_BRK_TEMP;

	// Protection sequence
	always_comb begin
		next_state = state;
		next_cause = cause;
		unique case (state)
			DMST_ST_RUN: begin
				// Serious faults never wait for a stop
				if (hi_trip) begin
					next_state = DMST_ST_TRIPPED;
					next_cause = hi_cause;
				end else if (low_prio && stop_first) begin
					next_state = DMST_ST_STOPPING;         // [RULE12]
				end else if (low_prio) begin
					next_state = DMST_ST_TRIPPED;          // [RULE11]
					next_cause = DMST_CAUSE_LOW_PRIO;
				end
			end

			DMST_ST_STOPPING: begin
				// A serious fault overrides the controlled stop
				if (hi_trip) begin
					next_state = DMST_ST_TRIPPED;
					next_cause = hi_cause;
				end else if (motor_stopped_in || !stop_first) begin
					next_state = DMST_ST_TRIPPED;          // [RULE12]
					next_cause = DMST_CAUSE_LOW_PRIO;
				end
			end

			DMST_ST_TRIPPED: begin
				// A fault still present keeps the trip; set wins over reset
				if (reset_evt && !hi_trip && !low_prio) begin
					next_state = DMST_ST_RUN;
					next_cause = DMST_CAUSE_NONE;
				end
			end
		endcase
	end

	// Protection state registers
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Power-up runs untripped
			state <= DMST_ST_RUN;
			cause <= DMST_CAUSE_NONE;
		end else begin
			state <= next_state;
			cause <= next_cause;
		end
	end

	// Registered status outputs
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_mode_out     <= DEFAULT_MODE;
			keypad_all_out      <= 1'b0;
			security_locked_out <= 1'b0;
			stop_request_out    <= 1'b0;
			drive_trip_out      <= 1'b0;
			trip_cause_out      <= DMST_CAUSE_NONE;
		end else begin
			active_mode_out     <= active_mode;
			keypad_all_out      <= ~level_zero & ~sec_locked; // [RULE5] [RULE6]
			security_locked_out <= sec_locked;
			// Stop and trip track next state
			stop_request_out    <= (next_state == DMST_ST_STOPPING);
			drive_trip_out      <= (next_state == DMST_ST_TRIPPED);
			trip_cause_out      <= next_cause;
		end
	end

endmodule : dmst_config

/* File: test/dmst_config_asserts.sv */
// Purpose: Port-level checks for the mode, security and trip-policy block
// Assumes: One clock domain; sees only the top module's ports
// Notes:   Bound into every dmst_config instance below
`include "dmst_defines.svh"

module dmst_config_asserts #(
	parameter logic [15:0] FW_VERSION = 16'h0064 // Same as design, arbitrary
) (
	input wire logic                ref_clk_in,        // Clock
	input wire logic                rst_n_in,          // Async reset, low
	input wire dmst_pkg::dmst_req_s req_in,            // Request
	input wire logic                motor_stopped_in,  // Standstill
	input wire logic [15:0]         param_rdata_out,   // Read value
	input wire logic                param_ack_out,     // Answered
	input wire logic                param_err_out,     // Refused
	input wire logic [2:0]          active_mode_out,   // Applied mode
	input wire logic                defaults_load_out, // Load pulse
	input wire logic                nv_store_out,      // Store pulse
	input wire logic                keypad_all_out,    // All menus
	input wire logic                stop_request_out,  // Stopping
	input wire logic                drive_trip_out,    // Tripped
	input wire dmst_pkg::dmst_cause_e trip_cause_out   // Cause
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmst_pkg::*;

	// Address decode of the request
	wire logic m0   = (req_in.menu == `DMST_MENU_BASIC);
	wire logic srl  = !req_in.from_keypad;
	wire logic at_m = m0 && (req_in.index == `DMST_IDX_MODE);
	wire logic at_s = m0 && (req_in.index == `DMST_IDX_SECURITY);
	wire logic at_v = m0 && (req_in.index == `DMST_IDX_VERSION);
	wire logic at_t = m0 && (req_in.index == `DMST_IDX_TRIP_ACT);
	wire logic code = (req_in.wdata == `DMST_UNLOCK_EUR) || (req_in.wdata == `DMST_UNLOCK_USA);

	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_MODE_CODE: assert property (active_mode_out inside {[3'h1:3'h4]})
		else $error("applied mode code out of range");
	AST_MODE_BAD: assert property (req_in.wr && srl && at_m && !(req_in.wdata inside {[16'h1:16'h4]})
		|=> param_ack_out && param_err_out) else $error("bad mode code accepted");
	AST_UNLOCK: assert property (req_in.wr && srl && req_in.index == 8'h00 && code
		|=> param_ack_out && !param_err_out) else $error("unlock code refused");
	AST_MODE_LOAD: assert property ($changed(active_mode_out) |-> $past(defaults_load_out) && $past(nv_store_out))
		else $error("mode changed without defaults load and store");
	AST_LOAD_PULSE: assert property (defaults_load_out |=> !defaults_load_out)
		else $error("defaults load longer than one cycle");
	AST_KP_MENU0: assert property (req_in.rd && !srl && !m0 && !keypad_all_out && !$past(req_in.wr)
		|=> param_err_out) else $error("keypad reached other menu at level 0");
	AST_KP_SEC: assert property (req_in.wr && !srl && at_s && req_in.wdata <= 16'h2
		|=> param_ack_out && !param_err_out) else $error("keypad security write refused");
	AST_VER_RO: assert property (req_in.wr && at_v |=> param_err_out && param_rdata_out == 16'h0)
		else $error("version write accepted");
	AST_VER_VAL: assert property (req_in.rd && srl && at_v |=> !param_err_out && param_rdata_out == FW_VERSION)
		else $error("version read wrong");
	AST_TA_WIDE: assert property (req_in.wr && srl && at_t && req_in.wdata > 16'hf |=> param_err_out)
		else $error("trip action above 15 accepted");
	AST_STOP_FIRST: assert property ($rose(stop_request_out) |-> !drive_trip_out)
		else $error("trip together with stop start");
	AST_STOP_TRIP: assert property (stop_request_out && motor_stopped_in && trip_cause_out == DMST_CAUSE_NONE
		|=> drive_trip_out) else $error("no trip after standstill");

	// Main scenarios reached
	COV_LOAD: cover property (defaults_load_out);
	COV_STOP: cover property (stop_request_out && motor_stopped_in);
	COV_REFUSE: cover property (param_ack_out && param_err_out);
endmodule : dmst_config_asserts

bind dmst_config dmst_config_asserts #(.FW_VERSION(FW_VERSION)) chk_u (.*);

/* File: test/dmst_host_model.sv */
// Purpose: Keypad or serial host issuing parameter requests
// Assumes: Requests change at the falling edge, one at a time
// Notes:   Released qualifiers show the inverse, never a stale copy
module dmst_host_model (
	input  wire logic          clk_in,   // Control clock
	input  wire logic          ack_in,   // Request answered
	input  wire logic          err_in,   // Request refused
	input  wire logic [15:0]   rdata_in, // Read value
	output dmst_pkg::dmst_req_s req_out  // Request to device
);
	timeunit 1ns;
	timeprecision 1ps;
	import dmst_pkg::*;

	// Idle at time zero
	initial begin
		req_out = '0;
	end

	// One access: strobe one cycle, answer taken in the next
	task automatic xfer(input logic w, input logic k, input logic [7:0] m,
		input logic [7:0] i, input logic [15:0] d, output logic e, output logic [15:0] r);
		@(negedge clk_in);
		req_out = '{wr: w, rd: !w, from_keypad: k, menu: m, index: i, wdata: d};
		@(negedge clk_in);
		// A missing ack makes the refusal flag unknown so the bench sees it
		e = (ack_in === 1'b1) ? err_in : 1'bx;
		r = rdata_in;
		req_out = '{wr: 1'b0, rd: 1'b0, from_keypad: !k, menu: ~m, index: ~i, wdata: ~d};
	endtask : xfer
endmodule : dmst_host_model

/* File: test/dmst_config_test.sv */
// Purpose: Self-checking bench for dmst_config
// Assumes: Host model makes requests; bench drives pins and faults
// Notes:   Table of accesses first, then reset, lock and trip cases
`include "dmst_defines.svh"

module dmst_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	import dmst_pkg::*;

	typedef struct packed {
		logic w, k;
		logic [7:0] m, i;
		logic [15:0] d;
		logic e;
		logic [15:0] r;
	} dmst_row_s;
	typedef struct packed {
		logic [3:0] ta;
		logic s;
		logic [9:0] f;
		logic t;
		dmst_cause_e c;
	} dmst_prot_s;

	localparam logic [15:0] FW = 16'h0123; // Version, arbitrary
	// Access rows: write, keypad, menu, index, data, refused, read value
	localparam dmst_row_s ROWS [15] = '{
		'{1'b1, 1'b0, 8'h00, 8'h00, 16'h04e5, 1'b0, 16'h0}, // Unlock
		'{1'b1, 1'b0, 8'h00, 8'h30, 16'h0002, 1'b0, 16'h0},
		'{1'b0, 1'b0, 8'h00, 8'h30, 16'h0000, 1'b0, 16'h2},
		'{1'b1, 1'b0, 8'h00, 8'h30, 16'h0005, 1'b1, 16'h0},
		'{1'b0, 1'b0, 8'h00, 8'h30, 16'h0000, 1'b0, 16'h2},
		'{1'b1, 1'b0, 8'h00, 8'h31, 16'h0000, 1'b0, 16'h0},
		'{1'b0, 1'b1, 8'h0a, 8'h25, 16'h0000, 1'b1, 16'h0},
		'{1'b1, 1'b1, 8'h00, 8'h31, 16'h0001, 1'b0, 16'h0},
		'{1'b1, 1'b1, 8'h0a, 8'h25, 16'h000f, 1'b0, 16'h0},
		'{1'b0, 1'b0, 8'h00, 8'h33, 16'h0000, 1'b0, 16'hf}, // Alias write read back at main address
		'{1'b1, 1'b0, 8'h00, 8'h33, 16'h0010, 1'b1, 16'h0},
		'{1'b1, 1'b0, 8'h00, 8'h33, 16'h0000, 1'b0, 16'h0},
		'{1'b0, 1'b0, 8'h00, 8'h32, 16'h0000, 1'b0, FW},
		'{1'b1, 1'b0, 8'h00, 8'h32, 16'h0007, 1'b1, 16'h0},
		'{1'b0, 1'b0, 8'h00, 8'h40, 16'h0000, 1'b1, 16'h0}  // Unmapped
	};
	// Trip rows: action bits, strap, faults, trip, cause
	localparam dmst_prot_s PROT [8] = '{
		'{4'h0, 1'b0, 10'h080, 1'b1, DMST_CAUSE_LOW_PRIO},
		'{4'h2, 1'b0, 10'h008, 1'b0, DMST_CAUSE_NONE},
		'{4'h0, 1'b0, 10'h008, 1'b1, DMST_CAUSE_XTR},
		'{4'h4, 1'b1, 10'h004, 1'b0, DMST_CAUSE_NONE},
		'{4'h4, 1'b0, 10'h004, 1'b1, DMST_CAUSE_PHASE},
		'{4'h0, 1'b1, 10'h002, 1'b1, DMST_CAUSE_BRK_TEMP},
		'{4'h8, 1'b1, 10'h002, 1'b0, DMST_CAUSE_NONE},
		'{4'h8, 1'b1, 10'h001, 1'b1, DMST_CAUSE_BRK_TEMP}
	};

	logic clk, rst_n, stopped, pin, strap, ack, err, load, store, kp_all, locked, stop, trip;
	logic usa;
	logic e, ld;
	logic [15:0] rdata, rd;
	logic [2:0] mode;
	dmst_req_s req;
	dmst_fault_s fault;
	dmst_cause_e cause;
	int n_fail = 0;
	int n_checks = 0;

	dmst_config #(.FW_VERSION(FW)) dut_u (.ref_clk_in(clk), .rst_n_in(rst_n), .req_in(req),
		.fault_in(fault), .motor_stopped_in(stopped), .drive_reset_in(pin),
		.size0_200v_in(strap), .param_rdata_out(rdata), .param_ack_out(ack),
		.param_err_out(err), .active_mode_out(mode), .defaults_usa_out(usa),
		.defaults_load_out(load), .nv_store_out(store), .keypad_all_out(kp_all),
		.security_locked_out(locked), .stop_request_out(stop), .drive_trip_out(trip),
		.trip_cause_out(cause));
	dmst_host_model host_u (.clk_in(clk), .ack_in(ack), .err_in(err), .rdata_in(rdata),
		.req_out(req));

	// Bit result compare
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : chk_bit

	// Word result compare
	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask : chk_vec

	// Reset button press; reports whether defaults were loaded
	task automatic press(output logic loaded);
		loaded = 1'b0;
		@(negedge clk);
		pin = 1'b1;
		repeat (6) begin
			@(posedge clk);
			#1;
			if (load === 1'b1) begin
				loaded = 1'b1;
				chk_bit(store, 1'b1, "store with load");
			end
		end
		@(negedge clk);
		pin = 1'b0;
		repeat (3) @(negedge clk);
	endtask : press

	// Verdict and end of run
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard, well past the expected run
	initial begin
		#100us;
		n_fail++;
		$display("CHECK FAILED at %0t: timeout", $time);
		conclude();
	end

	// Main sequence
	initial begin
		{rst_n, stopped, pin, strap} = '0;
		fault = '0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		chk_vec({13'h0, mode}, 16'h1, "mode after reset");
		chk_bit(trip, 1'b0, "trip after reset");
		$display("test reset done");
		foreach (ROWS[n]) begin
			host_u.xfer(ROWS[n].w, ROWS[n].k, ROWS[n].m, ROWS[n].i, ROWS[n].d, e, rd);
			chk_bit(e, ROWS[n].e, "refusal");
			chk_vec(rd, ROWS[n].r, "read value");
		end
		$display("test access table done");
		press(ld);
		chk_bit(ld, 1'b1, "defaults load");
		chk_vec({13'h0, mode}, 16'h2, "mode applied");
		host_u.xfer(1'b1, 1'b0, 8'h00, 8'h30, 16'h0003, e, rd);
		chk_bit(e, 1'b1, "locked mode write");
		host_u.xfer(1'b0, 1'b0, 8'h00, 8'h30, 16'h0000, e, rd);
		chk_vec(rd, 16'h2, "mode kept");
		$display("test mode change done");
		host_u.xfer(1'b1, 1'b0, 8'h00, 8'h31, 16'h0002, e, rd);
		press(ld);
		chk_bit(ld, 1'b0, "no load without change");
		chk_bit(locked, 1'b1, "security locked");
		host_u.xfer(1'b0, 1'b0, 8'h00, 8'h31, 16'h0000, e, rd);
		chk_vec(rd, 16'h0, "level after lock");
		host_u.xfer(1'b1, 1'b1, 8'h00, 8'h31, 16'h0001, e, rd);
		chk_bit(e, 1'b0, "keypad level write");
		@(negedge clk);
		chk_bit(kp_all, 1'b1, "all menus");
		$display("test security done");
		foreach (PROT[n]) begin
			strap = PROT[n].s;
			host_u.xfer(1'b1, 1'b0, 8'h00, 8'h33, {12'h0, PROT[n].ta}, e, rd);
			repeat (3) @(negedge clk);
			fault = dmst_fault_s'(PROT[n].f);
			repeat (2) @(negedge clk);
			chk_bit(trip, PROT[n].t, "trip");
			chk_vec({13'h0, cause}, {13'h0, PROT[n].c}, "cause");
			fault = '0;
			press(ld);
			chk_bit(trip, 1'b0, "trip cleared");
		end
		$display("test trip table done");
		host_u.xfer(1'b1, 1'b0, 8'h00, 8'h33, 16'h0001, e, rd);
		fault.output_overload_fault = 1'b1;
		repeat (2) @(negedge clk);
		chk_bit(stop, 1'b1, "stop first");
		chk_bit(trip, 1'b0, "no trip while stopping");
		stopped = 1'b1;
		repeat (2) @(negedge clk);
		chk_bit(trip, 1'b1, "trip at standstill");
		fault = '0;
		stopped = 1'b0;
		host_u.xfer(1'b1, 1'b0, 8'h00, 8'h00, 16'h04e6, e, rd);
		host_u.xfer(1'b1, 1'b0, 8'h00, 8'h30, 16'h0004, e, rd);
		press(ld);
		chk_bit(usa, 1'b1, "USA defaults");
		fault.output_overload_fault = 1'b1;
		repeat (2) @(negedge clk);
		chk_bit(trip, 1'b1, "regen trips at once");
		$display("test stop then trip done");
		conclude();
	end
endmodule : dmst_config_test
